// [design/t2crc_defs.vh]
// What this block does
// - Sixteen-bit count from machine cycles or pin events.
// - Timer ticks every six or twelve clocks; baud use ticks every one or two.
// - Capture mode overflow sets flag; requests interrupt.
// - Falling pin edge copies count into capture.
// - External capture also sets external flag.
// - Both flags share one interrupt request line.
// - Capture mode never reloads; counting continues.
// - Down-count enable resets clear; pin sets direction.
// - Up count overflows at FFFF, reloads capture.
// - External enable adds falling-edge reload, sets flag.
// - Direction high counts up, reloads at overflow.
// - Direction low counts down, underflow loads FFFF.
// - Up/down mode toggles external flag, no interrupt.
// - Receive clock select picks this timer's overflow.
// - External pin edges ignored when disabled or baud.
// - Transmit clock select picks this timer's overflow.
// - Baud use roll-overs request no interrupt.
`ifndef T2CRC_DEFS_VH
`define T2CRC_DEFS_VH

`define T2CRC_ADDR_W      4
`define T2CRC_OFS_CTRL    4'h0
`define T2CRC_OFS_MODE    4'h4
`define T2CRC_OFS_COUNT   4'h8
`define T2CRC_OFS_CAPT    4'hC

`define T2CRC_SEL_CTRL    3'h0
`define T2CRC_SEL_MODE    3'h1
`define T2CRC_SEL_COUNT   3'h2
`define T2CRC_SEL_CAPT    3'h3
`define T2CRC_SEL_NONE    3'h4

`define T2CRC_B_OVF       7
`define T2CRC_B_EXF       6
`define T2CRC_B_RCLK      5
`define T2CRC_B_TRANSMIT_CLOCK_SELECT      4
`define T2CRC_B_EXEN      3
`define T2CRC_B_RUN       2
`define T2CRC_B_CT        1
`define T2CRC_B_CPRL      0

`define T2CRC_B_DOWN_COUNT_ENABLE      0
`define T2CRC_B_CLKOE     1
`define T2CRC_B_SIXCLK    2
`define T2CRC_B_IRQEN     3

`define T2CRC_CTRL_RST    8'h00
`define T2CRC_MODE_RST    4'h0
`define T2CRC_COUNT_RST   16'h0000
`define T2CRC_CAPT_RST    16'h0000
`define T2CRC_COUNT_MAX   16'hFFFF

`define T2CRC_DIV_12CLK   4'hC
`define T2CRC_DIV_6CLK    4'h6
`define T2CRC_DIV_BAUD12  4'h2
`define T2CRC_DIV_BAUD6   4'h1

`define T2CRC_RESP_OKAY   2'h0
`define T2CRC_RESP_SLVERR 2'h2

`endif

// [design/t2crc_sync.v]
`timescale 1ns/1ps
`include "t2crc_defs.vh"

module t2crc_sync #(
  parameter W = 2
) (
  // Clock and reset.
  input  wire         clock,
  input  wire         reset_n,
  // Raw pins.
  input  wire [W-1:0] pin_in,
  // Synchronised level and falling-edge pulse.
  output wire [W-1:0] level,
  output wire [W-1:0] fall
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  reg [W-1:0] last_q;

  // Two flops, then a third stage for edge detection.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= {W{1'b1}};
      sync_q <= {W{1'b1}};
      last_q <= {W{1'b1}};
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign fall  = last_q & ~sync_q;

endmodule

// [design/t2crc_tick.v]
`timescale 1ns/1ps
`include "t2crc_defs.vh"

module t2crc_tick (
  // Clock and reset.
  input  wire       clock,
  input  wire       reset_n,
  // Division ratio in clocks per tick.
  input  wire [3:0] div,
  // One-cycle tick.
  output reg        tick_q
);

  reg  [3:0] cnt_q;
  wire       wrap;

  assign wrap = (cnt_q >= div - 4'h1);

  // Free-running divider; the tick marks one machine cycle, or one or two clocks in baud use.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q  <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= wrap ? 4'h0 : cnt_q + 4'h1;
      tick_q <= wrap;
    end
  end

endmodule

// [design/t2crc_top.v]
`timescale 1ns/1ps
`include "t2crc_defs.vh"

module t2crc_top (
  // Clock and reset.
  input  wire                     clock,
  input  wire                     reset_n,
  // AXI4-Lite write address.
  input  wire                     s_axi_awvalid,
  output reg                      s_axi_awready,
  input  wire [`T2CRC_ADDR_W-1:0] s_axi_awaddr,
  // AXI4-Lite write data.
  input  wire                     s_axi_wvalid,
  output reg                      s_axi_wready,
  input  wire [31:0]              s_axi_wdata,
  input  wire [3:0]               s_axi_wstrb,
  // AXI4-Lite write response.
  output reg                      s_axi_bvalid,
  input  wire                     s_axi_bready,
  output reg  [1:0]               s_axi_bresp,
  // AXI4-Lite read address.
  input  wire                     s_axi_arvalid,
  output reg                      s_axi_arready,
  input  wire [`T2CRC_ADDR_W-1:0] s_axi_araddr,
  // AXI4-Lite read data.
  output reg                      s_axi_rvalid,
  input  wire                     s_axi_rready,
  output reg  [31:0]              s_axi_rdata,
  output reg  [1:0]               s_axi_rresp,
  // External pins.
  input  wire                     count_input_pin,
  input  wire                     capture_direction_pin,
  // Serial port clocking.
  input  wire                     other_timer_overflow,
  output reg                      rx_baud_pulse_q,
  output reg                      tx_baud_pulse_q,
  // Timer interrupt request.
  output reg                      timer_irq_q
);

  //////////////////////////////////////////////////////////////////////////////

  function [2:0] t2crc_sel;
    input [`T2CRC_ADDR_W-1:0] a;
    begin
      case (a)
        `T2CRC_OFS_CTRL:  t2crc_sel = `T2CRC_SEL_CTRL;
        `T2CRC_OFS_MODE:  t2crc_sel = `T2CRC_SEL_MODE;
        `T2CRC_OFS_COUNT: t2crc_sel = `T2CRC_SEL_COUNT;
        `T2CRC_OFS_CAPT:  t2crc_sel = `T2CRC_SEL_CAPT;
        default:          t2crc_sel = `T2CRC_SEL_NONE;
      endcase
    end
  endfunction

  reg  [7:0]               ctrl_q;
  reg  [3:0]               mode_q;
  reg  [15:0]              count_q;
  reg  [15:0]              capt_q;
  reg                      aw_full_q;
  reg                      w_full_q;
  reg  [`T2CRC_ADDR_W-1:0] awaddr_q;
  reg  [31:0]              wdata_q;
  reg  [3:0]               wstrb_q;
  wire [1:0]               pin_level;
  wire [1:0]               pin_fall;
  wire                     mc_tick;
  reg  [3:0]               div;
  wire                     baud;
  wire                     cap_mode;
  wire                     down_count_enable;
  wire                     ext_edge;
  wire                     ext_cap;
  wire                     ext_load;
  wire                     count_evt;
  wire                     step;
  wire                     go_down;
  wire                     at_max;
  wire                     at_capt;
  wire                     roll_up;
  wire                     roll_down;
  wire                     roll;
  wire [2:0]               wsel;
  wire                     do_write;
  wire                     wr_ctrl;
  wire                     wr_mode;
  wire                     wr_cnt;
  wire                     wr_capt;

  //////////////////////////////////////////////////////////////////////////////

  t2crc_sync #(
    .W (2)
  ) u_sync (
    .clock   (clock),
    .reset_n (reset_n),
    .pin_in  ({capture_direction_pin, count_input_pin}),
    .level   (pin_level),
    .fall    (pin_fall)
  );

  // Baud use runs faster than the machine-cycle rate.
  always @* begin
    if (baud)
      div = mode_q[`T2CRC_B_SIXCLK] ? `T2CRC_DIV_BAUD6 : `T2CRC_DIV_BAUD12;
    else
      div = mode_q[`T2CRC_B_SIXCLK] ? `T2CRC_DIV_6CLK : `T2CRC_DIV_12CLK;
  end

  t2crc_tick u_tick (
    .clock   (clock),
    .reset_n (reset_n),
    .div     (div),
    .tick_q  (mc_tick)
  );

  //////////////////////////////////////////////////////////////////////////////

  assign baud      = ctrl_q[`T2CRC_B_RCLK] | ctrl_q[`T2CRC_B_TRANSMIT_CLOCK_SELECT];
  assign cap_mode  = ctrl_q[`T2CRC_B_CPRL] & ~baud;
  assign down_count_enable      = mode_q[`T2CRC_B_DOWN_COUNT_ENABLE] & ~cap_mode & ~baud;
  assign ext_edge  = ctrl_q[`T2CRC_B_EXEN] & ~baud & pin_fall[1];
  assign ext_cap   = ext_edge & cap_mode;
  assign ext_load  = ext_edge & ~cap_mode & ~down_count_enable;
  assign count_evt = ctrl_q[`T2CRC_B_CT] ? pin_fall[0] : mc_tick;
  assign step      = ctrl_q[`T2CRC_B_RUN] & count_evt;
  assign go_down   = down_count_enable & ~pin_level[1];
  assign at_max    = (count_q == `T2CRC_COUNT_MAX);
  assign at_capt   = (count_q == capt_q);
  assign roll_up   = step & ~go_down & at_max;
  assign roll_down = step & go_down & at_capt;
  assign roll      = roll_up | roll_down;

  assign wsel     = t2crc_sel(awaddr_q);
  assign do_write = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign wr_ctrl  = do_write & (wsel == `T2CRC_SEL_CTRL) & wstrb_q[0];
  assign wr_mode  = do_write & (wsel == `T2CRC_SEL_MODE) & wstrb_q[0];
  assign wr_cnt   = do_write & (wsel == `T2CRC_SEL_COUNT);
  assign wr_capt  = do_write & (wsel == `T2CRC_SEL_CAPT);

  //////////////////////////////////////////////////////////////////////////////

  reg [15:0] count_d;
  reg [15:0] capt_d;
  reg [7:0]  ctrl_d;

  // Count register.
  always @* begin
    count_d = count_q;
    if (step) begin
      if (go_down)
        count_d = at_capt ? `T2CRC_COUNT_MAX : count_q - 16'h0001;
      else if (at_max)
        count_d = cap_mode ? 16'h0000 : capt_q;
      else
        count_d = count_q + 16'h0001;
    end
    if (ext_load)
      count_d = capt_q;
    if (wr_cnt) begin
      if (wstrb_q[0])
        count_d[7:0] = wdata_q[7:0];
      if (wstrb_q[1])
        count_d[15:8] = wdata_q[15:8];
    end
  end

  // Capture register; a hardware capture wins over a software write.
  always @* begin
    capt_d = capt_q;
    if (wr_capt) begin
      if (wstrb_q[0])
        capt_d[7:0] = wdata_q[7:0];
      if (wstrb_q[1])
        capt_d[15:8] = wdata_q[15:8];
    end
    if (ext_cap)
      capt_d = count_q;
  end

  // Control register; hardware set wins over a software clear.
  always @* begin
    ctrl_d = ctrl_q;
    if (wr_ctrl)
      ctrl_d = wdata_q[7:0];
    if (roll & ~baud)
      ctrl_d[`T2CRC_B_OVF] = 1'b1;
    if (ext_cap | ext_load)
      ctrl_d[`T2CRC_B_EXF] = 1'b1;
    if (down_count_enable & roll)
      ctrl_d[`T2CRC_B_EXF] = ~ctrl_d[`T2CRC_B_EXF];
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q  <= `T2CRC_CTRL_RST;
      mode_q  <= `T2CRC_MODE_RST;
      count_q <= `T2CRC_COUNT_RST;
      capt_q  <= `T2CRC_CAPT_RST;
    end else begin
      ctrl_q  <= ctrl_d;
      count_q <= count_d;
      capt_q  <= capt_d;
      if (wr_mode)
        mode_q <= wdata_q[3:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  wire exf_irq = ctrl_q[`T2CRC_B_EXF] & ~down_count_enable;
  wire irq_d   = mode_q[`T2CRC_B_IRQEN] &
                 (ctrl_q[`T2CRC_B_OVF] | exf_irq);

  // Serial clock pulses and interrupt request.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_baud_pulse_q <= 1'b0;
      tx_baud_pulse_q <= 1'b0;
      timer_irq_q     <= 1'b0;
    end else begin
      rx_baud_pulse_q <= ctrl_q[`T2CRC_B_RCLK] ? roll_up :
                         other_timer_overflow;
      tx_baud_pulse_q <= ctrl_q[`T2CRC_B_TRANSMIT_CLOCK_SELECT] ? roll_up :
                         other_timer_overflow;
      timer_irq_q     <= irq_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire aw_full_d = (aw_full_q | aw_take) & ~do_write;
  wire w_full_d  = (w_full_q | w_take) & ~do_write;

  // Write channels.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      awaddr_q      <= {`T2CRC_ADDR_W{1'b0}};
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `T2CRC_RESP_OKAY;
    end else begin
      aw_full_q     <= aw_full_d;
      w_full_q      <= w_full_d;
      s_axi_awready <= ~aw_full_d;
      s_axi_wready  <= ~w_full_d;
      if (aw_take)
        awaddr_q <= s_axi_awaddr;
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wsel == `T2CRC_SEL_NONE) ? `T2CRC_RESP_SLVERR :
                        `T2CRC_RESP_OKAY;
      end else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  wire       ar_take = s_axi_arvalid & s_axi_arready;
  wire [2:0] rsel    = t2crc_sel(s_axi_araddr);
  reg  [31:0] rd_val;

  always @* begin
    case (rsel)
      `T2CRC_SEL_CTRL:  rd_val = {24'h000000, ctrl_q};
      `T2CRC_SEL_MODE:  rd_val = {28'h0000000, mode_q};
      `T2CRC_SEL_COUNT: rd_val = {16'h0000, count_q};
      `T2CRC_SEL_CAPT:  rd_val = {16'h0000, capt_q};
      default:          rd_val = 32'h00000000;
    endcase
  end

  // Read channels.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `T2CRC_RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= (rsel == `T2CRC_SEL_NONE) ? `T2CRC_RESP_SLVERR :
                         `T2CRC_RESP_OKAY;
      end else if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid  <= 1'b0;
          s_axi_arready <= 1'b1;
        end
      end else
        s_axi_arready <= 1'b1;
    end
  end

endmodule

// [test/t2crc_pins.sv]
`timescale 1ns/1ps
// Far-side pins: count pin idles high, capture pin at its set direction; both are pulled low briefly for events.
module t2crc_pins (
  // Clock.
  input  wire logic clock,
  // Pins.
  output logic      count_input_pin,
  output logic      capture_direction_pin
);
  logic dir_q = 1'b1;
  initial count_input_pin = 1'b1;
  initial capture_direction_pin = 1'b1;
  // Low pulse of w cycles on one pin, then back to its idle level.
  task fall(input bit cap, input int w);
    repeat (2) @(posedge clock);
    if (cap) capture_direction_pin <= 1'b0;
    else count_input_pin <= 1'b0;
    repeat (w) @(posedge clock);
    capture_direction_pin <= dir_q;
    count_input_pin <= 1'b1;
    repeat (6) @(posedge clock);
  endtask
  // Level on the capture pin picks the count direction.
  task set_dir(input logic d);
    @(posedge clock);
    dir_q = d;
    capture_direction_pin <= d;
  endtask
endmodule

// [test/t2crc_properties.sv]
`timescale 1ns/1ps
module t2crc_properties (
  // Clock and reset.
  input wire logic        clock,
  input wire logic        reset_n,
  // Register bus.
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Interrupt.
  input wire logic        timer_irq_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("no bresp");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("no rvalid");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  aw_block_a: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready) else $error("awready after address taken");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready during rdata");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 0)
    else $error("upper read bits set");
  irq_fall_a: assert property ($fell(timer_irq_q) |->
    $past(s_axi_wvalid && s_axi_wready, 1) ||
    $past(s_axi_wvalid && s_axi_wready, 2) ||
    $past(s_axi_wvalid && s_axi_wready, 3)) else $error("irq cleared");
endmodule

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
  localparam logic [3:0] CT = 4'h0, MD = 4'h4, CN = 4'h8, CP = 4'hC;
  logic clock = 1'b0, reset_n = 1'b0, s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, other_timer_overflow = 1'b0, oto_d = 1'b0;
  logic chk_ser = 1'b1, rst_d = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, rnd;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, rx_baud_pulse_q, tx_baud_pulse_q, timer_irq_q;
  wire count_input_pin, capture_direction_pin;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int error_cnt = 0, num_checks = 0, seed = 32'hFE02, n, k, t;
  logic [33:0] exp_q[$];
  always #2.5 clock = ~clock;
  t2crc_top t2crc_top_i (.*);
  t2crc_pins t2crc_pins_i (.*);
  //////////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("errors %0d checks %0d", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task fail(input string m);
    error_cnt++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask
  task chk_bit(input logic g, input logic e, input string m);
    num_checks++;
    if (g !== e) fail(m);
  endtask
  task chk_rd(input logic [33:0] g, input logic [33:0] e);
    num_checks++;
    if (g !== e) fail($sformatf("read %h expected %h", g, e));
  endtask
  task tmo(input int c);
    if (c >= 64) begin
      fail("timeout");
      finish_test();
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge clock);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_bready <= 1'b1;
    for (n = 0; n < 64 && !(ad && dd); n++) begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) ad = 1'b1;
      if (s_axi_wvalid && s_axi_wready) dd = 1'b1;
      if (ad) s_axi_awvalid <= 1'b0;
      if (dd) s_axi_wvalid <= 1'b0;
    end
    tmo(n);
    n = 0;
    do begin @(posedge clock); n++; end while (!s_axi_bvalid && n < 64);
    s_axi_bready <= 1'b0;
    tmo(n);
    chk_bit(s_axi_bresp === 2'h0, 1'b1, "bresp");
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e,
          input logic [1:0] r = 2'h0);
    @(posedge clock);
    exp_q.push_back({r, 16'h0000, e});
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin @(posedge clock); n++; end while (!s_axi_arready && n < 64);
    s_axi_arvalid <= 1'b0;
    tmo(n);
    n = 0;
    do begin @(posedge clock); n++; end while (!s_axi_rvalid && n < 64);
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask
  //////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    if (s_axi_rvalid && s_axi_rready)
      chk_rd({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    if (rst_d && chk_ser) begin
      chk_bit(rx_baud_pulse_q, oto_d, "rx pulse");
      chk_bit(tx_baud_pulse_q, oto_d, "tx pulse");
    end
    rnd = $random(seed);
    rst_d <= reset_n;
    oto_d <= other_timer_overflow;
    other_timer_overflow <= rnd[0];
  end
  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    rd(CT, 16'h0000);
    rd(MD, 16'h0000);
    rd(CN, 16'h0000);
    rd(CP, 16'h0000);
    rd(4'h2, 16'h0000, 2'h2);
    wr(MD, 16'h0008);
    wr(CT, 16'h000F);
    wr(CN, 16'hABCD);
    t2crc_pins_i.fall(1'b1, 2);
    rd(CP, 16'hABCD);
    rd(CT, 16'h004F);
    rd(CN, 16'hABCD);
    chk_bit(timer_irq_q, 1'b1, "irq ext");
    wr(CT, 16'h0007);
    wr(CN, 16'h1111);
    t2crc_pins_i.fall(1'b1, 5);
    rd(CP, 16'hABCD);
    rd(CT, 16'h0007);
    wr(CT, 16'h0006);
    wr(CN, 16'h0010);
    for (k = 1; k < 9; k = k * 2) t2crc_pins_i.fall(1'b0, k);
    rd(CN, 16'h0014);
    wr(CP, 16'h5555);
    wr(CT, 16'h000E);
    wr(CN, 16'h0100);
    t2crc_pins_i.fall(1'b1, 1);
    rd(CN, 16'h5555);
    rd(CT, 16'h004E);
    wr(CT, 16'h0006);
    wr(CN, 16'hFFFF);
    t2crc_pins_i.fall(1'b0, 3);
    rd(CN, 16'h5555);
    rd(CT, 16'h0086);
    wr(MD, 16'h0009);
    wr(CT, 16'h0006);
    wr(CP, 16'h0020);
    wr(CN, 16'h0021);
    t2crc_pins_i.set_dir(1'b0);
    repeat (2) t2crc_pins_i.fall(1'b0, 2);
    rd(CN, 16'hFFFF);
    rd(CT, 16'h00C6);
    t2crc_pins_i.set_dir(1'b1);
    t2crc_pins_i.fall(1'b0, 2);
    rd(CN, 16'h0020);
    rd(CT, 16'h0086);
    wr(CT, 16'h0046);
    @(posedge clock);
    chk_bit(timer_irq_q, 1'b0, "irq updown");
    chk_ser <= 1'b0;
    wr(MD, 16'h0008);
    wr(CP, 16'hFFFE);
    wr(CN, 16'hFFFE);
    wr(CT, 16'h0035);
    repeat (10) @(posedge clock);
    k = 0;
    t = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clock);
      k += rx_baud_pulse_q;
      t += tx_baud_pulse_q;
    end
    chk_bit(k == 10, 1'b1, "rx baud count");
    chk_bit(t == 10, 1'b1, "tx baud count");
    rd(CT, 16'h0035);
    chk_bit(timer_irq_q, 1'b0, "irq baud");
    wr(CT, 16'h0000);
    wr(CN, 16'h0777);
    chk_ser <= 1'b1;
    repeat (50) @(posedge clock);
    rd(CN, 16'h0777);
    for (k = 0; k < 2; k++) begin
      wr(MD, k ? 16'h000C : 16'h0008);
      wr(CN, 16'h0000);
      wr(CT, 16'h0004);
      repeat (116) @(posedge clock);
      wr(CT, 16'h0000);
      rd(CN, k ? 16'h0014 : 16'h000A);
    end
    repeat (4) @(posedge clock);
    finish_test();
  end
endmodule
bind t2crc_top t2crc_properties t2crc_properties_i (.*);
